// >>> src/serial_module_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "serial_ctrl_regs.svh"
module serial_module_ctrl
    import serial_ctrl_pkg::*;
(
    input  wire logic       SYS_CLK,
    input  wire logic       RST_N,
    input  wire bus_req_s   BUS_REQ,
    output logic [15:0]     BUS_RDATA,
    output logic            BUS_ACK,
    input  wire logic       FREEZE,
    input  wire logic       SYNC_REQ,
    input  wire logic       ASYNC_REQ,
    input  wire logic       IACK,
    input  wire logic [2:0] IACK_LEVEL,
    output logic [7:0]      VECTOR,
    output logic            VEC_VALID,
    output logic [7:1]      IRQ_N,
    input  wire logic       RXD,
    output logic            BAUD_TICK,
    output async_cfg_s      ASYNC_CFG,
    output logic            STOPPED,
    output logic [3:0]      QUEUE_PTR,
    output logic            QUEUE_BUSY,
    output logic            HALT_ACK,
    output logic [3:0]      CS_N,
    output logic            SHIFT_STEP,
    output logic            RAM_RD,
    output logic            RAM_WR,
    output logic [1:0]      RAM_BE,
    output logic [6:0]      RAM_ADDR,
    output logic [15:0]     RAM_WDATA,
    input  wire logic [15:0] RAM_RDATA
);
    logic        stop_q;
    logic        freeze_halt_enable_q;
    logic        freeze_spare_bit_q;
    logic [2:0]  slvl_q;
    logic [2:0]  alvl_q;
    logic [7:1]  vec_q;
    queue_cfg_s  qcfg_q;
    logic [12:0] baud_q;
    logic        noise_q;
    logic        run;
    logic        sel_ram;
    logic [7:0]  addr;
    logic [15:0] wd;
    logic        wr_reg;
    logic        rd_reg;
    logic [15:0] rd_mux;
    logic        ram_pend_q;
    logic [13:0] baud_cnt_q;
    logic        rx_m_q;
    logic        rx_s_q;
    logic [2:0]  hist_q;
    logic        glitch;
    logic [3:0]  sck_cnt_q;
    logic        sck_tick_q;
    logic        sync_on;
    logic        async_on;
    logic        sync_win;
    logic        async_win;
    logic [2:0]  win_lvl;

    // Stop is modelled as a clock enable: the dividers, receive sampling, queue sequencer and queue
    // RAM reads advance only while run is high; the register file keeps accepting writes.
    assign run     = ~stop_q;
    assign addr    = BUS_REQ.addr;
    assign wd      = BUS_REQ.wdata;
    assign sel_ram = addr[`RAM_SEL_BIT];
    assign wr_reg  = BUS_REQ.wr & ~sel_ram;
    assign rd_reg  = BUS_REQ.rd & ~sel_ram;

    // Configuration word
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            stop_q <= `CFG_STOP_RST;
            freeze_halt_enable_q <= 1'b0;
            freeze_spare_bit_q <= 1'b0;
        end
        else if (wr_reg && addr == `OFS_CONFIG && BUS_REQ.be[1])
        begin
            stop_q <= wd[`CFG_STOP_BIT];
            freeze_halt_enable_q <= wd[`CFG_FREEZE_HALT_ENABLE_BIT];
            freeze_spare_bit_q <= wd[`CFG_FREEZE_SPARE_BIT_BIT];
        end
    end

    // Level byte high, vector byte low in one word
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            slvl_q <= 3'h0;
            alvl_q <= 3'h0;
            vec_q  <= 7'(`VEC_RESET >> 1);
        end
        else if (wr_reg && addr == `OFS_IRQ)
        begin
            if (BUS_REQ.be[1])
            begin
                slvl_q <= wd[`LVL_SYNC_MSB:`LVL_SYNC_LSB];
                alvl_q <= wd[`LVL_ASYNC_MSB:`LVL_ASYNC_LSB];
            end
            if (BUS_REQ.be[0])
            begin
                vec_q <= wd[7:1];
            end
        end
    end

    // Queue control word
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            qcfg_q <= '0;
        end
        else if (wr_reg && addr == `OFS_QUEUE)
        begin
            if (BUS_REQ.be[1])
            begin
                qcfg_q.en       <= wd[`Q_EN_BIT];
                qcfg_q.wrap     <= wd[`Q_WRAP_BIT];
                qcfg_q.halt_req <= wd[`Q_HALT_BIT];
                qcfg_q.cs       <= wd[`Q_CS_MSB:`Q_CS_LSB];
            end
            if (BUS_REQ.be[0])
            begin
                qcfg_q.end_ptr  <= wd[7:4];
                qcfg_q.len_code <= wd[3:0];
            end
        end
    end

    // Async port control and baud modulus
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ASYNC_CFG <= '0;
            baud_q    <= 13'h0000;
        end
        else
        begin
            if (wr_reg && addr == `OFS_ASYNC && BUS_REQ.be[0])
            begin
                ASYNC_CFG <= wd[4:0];
            end
            if (wr_reg && addr == `OFS_BAUD)
            begin
                if (BUS_REQ.be[1])
                begin
                    baud_q[12:8] <= wd[12:8];
                end
                if (BUS_REQ.be[0])
                begin
                    baud_q[7:0] <= wd[7:0];
                end
            end
        end
    end

    // Read data; unimplemented bits and the test word read as zero, the vector low bit reads as one while running
    always_comb
    begin
        rd_mux = 16'h0000;
        case (addr)
            `OFS_CONFIG: rd_mux = {stop_q, freeze_halt_enable_q, freeze_spare_bit_q, 13'h0000};
            `OFS_IRQ:    rd_mux = {2'h0, slvl_q, alvl_q, vec_q, 1'b1};
            `OFS_QUEUE:  rd_mux = {qcfg_q.en, qcfg_q.wrap, qcfg_q.halt_req, 1'b0,
                                   qcfg_q.cs, qcfg_q.end_ptr, qcfg_q.len_code};
            `OFS_ASYNC:  rd_mux = {11'h000, ASYNC_CFG};
            `OFS_BAUD:   rd_mux = {3'h0, baud_q};
            `OFS_STATUS: rd_mux = {HALT_ACK, QUEUE_BUSY, 5'h00, noise_q, QUEUE_PTR, 4'h0};
            default:     rd_mux = 16'h0000;
        endcase
        if (stop_q && addr != `OFS_CONFIG)
        begin
            rd_mux = 16'h0000;
        end
    end

    // Bus answer: registers one cycle, queue RAM reads two cycles while running
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            BUS_ACK    <= 1'b0;
            BUS_RDATA  <= 16'h0000;
            ram_pend_q <= 1'b0;
        end
        else
        begin
            BUS_ACK <= 1'b0;
            if (ram_pend_q)
            begin
                BUS_ACK    <= 1'b1;
                BUS_RDATA  <= RAM_RDATA;
                ram_pend_q <= 1'b0;
            end
            else if (BUS_REQ.rd && sel_ram && run)
            begin
                ram_pend_q <= 1'b1;
            end
            else if (BUS_REQ.rd || BUS_REQ.wr)
            begin
                BUS_ACK   <= 1'b1;
                BUS_RDATA <= rd_reg ? rd_mux : 16'h0000;
            end
        end
    end

    // Queue RAM port
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            RAM_RD    <= 1'b0;
            RAM_WR    <= 1'b0;
            RAM_BE    <= 2'h0;
            RAM_ADDR  <= 7'h00;
            RAM_WDATA <= 16'h0000;
        end
        else
        begin
            RAM_RD <= BUS_REQ.rd & sel_ram & run;
            RAM_WR <= BUS_REQ.wr & sel_ram;
            if ((BUS_REQ.rd || BUS_REQ.wr) && sel_ram)
            begin
                RAM_BE    <= BUS_REQ.be;
                RAM_ADDR  <= addr[6:0];
                RAM_WDATA <= wd;
            end
        end
    end

    // Interrupt request lines and vector answer
    assign sync_on   = SYNC_REQ && slvl_q != 3'h0;
    assign async_on  = ASYNC_REQ && alvl_q != 3'h0;
    assign sync_win  = sync_on && (!async_on || slvl_q >= alvl_q);
    assign async_win = async_on && !sync_win;
    assign win_lvl   = sync_win ? slvl_q : alvl_q;

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            IRQ_N     <= 7'h7F;
            VECTOR    <= `VEC_RESET;
            VEC_VALID <= 1'b0;
        end
        else
        begin
            for (int n = 1; n < 8; n++)
            begin
                IRQ_N[n] <= !((sync_on && slvl_q == 3'(n)) ||
                              (async_on && alvl_q == 3'(n)));
            end
            VEC_VALID <= 1'b0;
            if (IACK && (sync_win || async_win) && win_lvl == IACK_LEVEL)
            begin
                VECTOR    <= {vec_q, sync_win};
                VEC_VALID <= 1'b1;
            end
        end
    end

    // Modulus baud divider: a tick every 2*modulus clocks gives 16 samples a bit
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            baud_cnt_q <= 14'h0000;
            BAUD_TICK  <= 1'b0;
        end
        else if (!run || baud_q == 13'h0000)
        begin
            baud_cnt_q <= 14'h0000;
            BAUD_TICK  <= 1'b0;
        end
        else if (baud_cnt_q == 14'h0000)
        begin
            baud_cnt_q <= {baud_q, 1'b0} - 14'h0001;
            BAUD_TICK  <= 1'b1;
        end
        else
        begin
            baud_cnt_q <= baud_cnt_q - 14'h0001;
            BAUD_TICK  <= 1'b0;
        end
    end

    // Receive line noise: a lone sample differing from both neighbours
    assign glitch = (hist_q[1] ^ hist_q[0]) & (hist_q[1] ^ hist_q[2]);

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rx_m_q  <= 1'b1;
            rx_s_q  <= 1'b1;
            hist_q  <= 3'h7;
            noise_q <= 1'b0;
        end
        else
        begin
            rx_m_q <= RXD;
            rx_s_q <= rx_m_q;
            if (run && BAUD_TICK && ASYNC_CFG.rx_en)
            begin
                hist_q <= {hist_q[1:0], rx_s_q};
            end
            // Set wins over a write-one clear in the same cycle
            if (run && BAUD_TICK && ASYNC_CFG.rx_en && glitch)
            begin
                noise_q <= 1'b1;
            end
            else if (wr_reg && addr == `OFS_STATUS && BUS_REQ.be[1] && wd[`ST_NOISE_BIT])
            begin
                noise_q <= 1'b0;
            end
        end
    end

    // Shift step divider for the queued port
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            sck_cnt_q  <= 4'h0;
            sck_tick_q <= 1'b0;
        end
        else if (run)
        begin
            sck_tick_q <= (sck_cnt_q == 4'h0);
            sck_cnt_q  <= (sck_cnt_q == 4'h0) ? `SCK_DIV - 4'h1 : sck_cnt_q - 4'h1;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            STOPPED <= `CFG_STOP_RST;
        end
        else
        begin
            STOPPED <= stop_q;
        end
    end

    queue_sequencer u_seq (
        .clk         (SYS_CLK),
        .rst_n       (RST_N),
        .run         (run),
        .tick        (sck_tick_q),
        .cfg         (qcfg_q),
        .freeze_halt (FREEZE & freeze_halt_enable_q),
        .ptr_q       (QUEUE_PTR),
        .busy_q      (QUEUE_BUSY),
        .halt_ack_q  (HALT_ACK),
        .cs_n_q      (CS_N),
        .shift_q     (SHIFT_STEP)
    );

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    stop_after_reset_a: assert property ($past(!RST_N) |-> stop_q)
        else $error("stop bit not set after reset");

    stop_hold_a: assert property (stop_q && !(wr_reg && addr == `OFS_CONFIG && BUS_REQ.be[1])
        |=> stop_q && sck_tick_q == $past(sck_tick_q))
        else $error("module left stop without a config write");

    stop_read_zero_a: assert property ((rd_reg && stop_q && addr != `OFS_CONFIG)
        |=> BUS_ACK && BUS_RDATA == 16'h0000)
        else $error("non-config register read not zero in stop");

    ram_read_block_a: assert property ((BUS_REQ.rd && sel_ram && stop_q)
        |=> !RAM_RD && BUS_ACK && BUS_RDATA == 16'h0000)
        else $error("queue RAM read passed during stop");

    stop_write_a: assert property ((wr_reg && stop_q && addr == `OFS_BAUD && BUS_REQ.be == 2'h3)
        |=> baud_q == $past(wd[12:0]) && BUS_ACK)
        else $error("register write lost during stop");

    test_word_zero_a: assert property ((rd_reg && run && addr == `OFS_TEST)
        |=> BUS_RDATA == 16'h0000)
        else $error("test word did not read zero");

    vec_bit_one_a: assert property ((rd_reg && run && addr == `OFS_IRQ)
        |=> BUS_RDATA[0] && BUS_RDATA[7:1] == $past(vec_q))
        else $error("vector low bit did not read one");

    vec_source_a: assert property ((IACK && sync_on && async_on && slvl_q == alvl_q
        && slvl_q == IACK_LEVEL) |=> VEC_VALID && VECTOR[0])
        else $error("queued port lost equal level tie");

    irq_level_map_a: assert property ((sync_on && slvl_q == 3'h7 && !async_on)
        |=> IRQ_N == 7'h3F)
        else $error("level seven request did not drive line seven only");

    irq_disabled_a: assert property ((slvl_q == 3'h0 && alvl_q == 3'h0) ##1 (slvl_q == 3'h0
        && alvl_q == 3'h0) |-> IRQ_N == 7'h7F)
        else $error("request line active with both levels zero");

endmodule
`default_nettype wire

// >>> src/serial_ctrl_regs.svh
`ifndef SERIAL_CTRL_REGS_SVH
`define SERIAL_CTRL_REGS_SVH

// Byte offsets of the register words
`define OFS_CONFIG     8'h00
`define OFS_TEST       8'h02
`define OFS_IRQ        8'h04
`define OFS_QUEUE      8'h06
`define OFS_ASYNC      8'h08
`define OFS_BAUD       8'h0A
`define OFS_STATUS     8'h0C
`define RAM_SEL_BIT    7

// Configuration word
`define CFG_STOP_BIT   15
`define CFG_FREEZE_HALT_ENABLE_BIT   14
`define CFG_FREEZE_SPARE_BIT_BIT   13
`define CFG_STOP_RST   1'b1

// Level / vector word
`define LVL_SYNC_MSB   13
`define LVL_SYNC_LSB   11
`define LVL_ASYNC_MSB  10
`define LVL_ASYNC_LSB  8
`define VEC_RESET      8'h0F

// Queue control word
`define Q_EN_BIT       15
`define Q_WRAP_BIT     14
`define Q_HALT_BIT     13
`define Q_CS_MSB       11
`define Q_CS_LSB       8

// Status word
`define ST_HALT_ACK_FLAG_BIT   15
`define ST_BUSY_BIT    14
`define ST_NOISE_BIT   8

// System clocks per shift step of the queued port
`define SCK_DIV        4'h4

`endif

// >>> src/serial_ctrl_pkg.sv
`default_nettype none
package serial_ctrl_pkg;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [1:0]  be;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } bus_req_s;

    typedef struct packed {
        logic       en;
        logic       wrap;
        logic       halt_req;
        logic [3:0] cs;
        logic [3:0] end_ptr;
        logic [3:0] len_code;
    } queue_cfg_s;

    typedef struct packed {
        logic tx_en;
        logic rx_en;
        logic nine_bit;
        logic par_en;
        logic par_odd;
    } async_cfg_s;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_HALT, SEQ_DONE} seq_state_e;

endpackage
`default_nettype wire

// >>> src/queue_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module queue_sequencer
    import serial_ctrl_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic       tick,
    input  wire queue_cfg_s cfg,
    input  wire logic       freeze_halt,
    output logic [3:0]      ptr_q,
    output logic            busy_q,
    output logic            halt_ack_q,
    output logic [3:0]      cs_n_q,
    output logic            shift_q
);
    seq_state_e state_q;
    logic [4:0] bits_q;
    logic [4:0] len;
    logic       stop_req;
    logic       last_w;

    assign len      = (cfg.len_code == 4'h0) ? 5'h10 :
                      (cfg.len_code < 4'h8) ? 5'h08 : {1'b0, cfg.len_code};
    assign stop_req = cfg.halt_req | freeze_halt;
    assign last_w   = (ptr_q == cfg.end_ptr);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q    <= SEQ_IDLE;
            ptr_q      <= 4'h0;
            bits_q     <= 5'h00;
            busy_q     <= 1'b0;
            halt_ack_q <= 1'b0;
            cs_n_q     <= 4'hF;
            shift_q    <= 1'b0;
        end
        else if (run)
        begin
            shift_q <= 1'b0;
            case (state_q)
                SEQ_IDLE:
                begin
                    if (stop_req)
                    begin
                        state_q    <= SEQ_HALT;
                        halt_ack_q <= 1'b1;
                    end
                    else if (cfg.en)
                    begin
                        state_q <= SEQ_RUN;
                        bits_q  <= len;
                        busy_q  <= 1'b1;
                        cs_n_q  <= ~cfg.cs;
                    end
                end
                SEQ_RUN:
                begin
                    if (tick)
                    begin
                        shift_q <= 1'b1;
                        if (bits_q == 5'h01)
                        begin
                            cs_n_q <= 4'hF;
                            ptr_q  <= last_w ? 4'h0 : ptr_q + 4'h1;
                            if (stop_req)
                            begin
                                state_q    <= SEQ_HALT;
                                halt_ack_q <= 1'b1;
                            end
                            else if ((last_w && !cfg.wrap) || !cfg.en)
                            begin
                                state_q <= last_w && !cfg.wrap ? SEQ_DONE : SEQ_IDLE;
                                busy_q  <= 1'b0;
                            end
                            else
                            begin
                                bits_q <= len;
                                cs_n_q <= ~cfg.cs;
                            end
                        end
                        else
                        begin
                            bits_q <= bits_q - 5'h01;
                        end
                    end
                end
                SEQ_HALT:
                begin
                    if (!stop_req)
                    begin
                        state_q    <= SEQ_IDLE;
                        halt_ack_q <= 1'b0;
                        busy_q     <= 1'b0;
                    end
                end
                SEQ_DONE:
                begin
                    if (stop_req)
                    begin
                        state_q    <= SEQ_HALT;
                        halt_ack_q <= 1'b1;
                    end
                    else if (!cfg.en)
                    begin
                        state_q <= SEQ_IDLE;
                    end
                end
                default:
                begin
                    state_q <= SEQ_IDLE;
                end
            endcase
        end
    end

    halt_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q == SEQ_HALT && stop_req) |=> (halt_ack_q && !shift_q && cs_n_q == 4'hF))
        else $error("halt acknowledge dropped or transfer started while halted");

    freeze_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
        (run && state_q == SEQ_RUN && tick && bits_q == 5'h01 && freeze_halt)
        |=> (state_q == SEQ_HALT) ##1 (state_q == SEQ_HALT || !stop_req || !run))
        else $error("queue did not halt at transfer boundary on freeze");

endmodule
`default_nettype wire

// >>> tb/host_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_model
    import serial_ctrl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        ack,
    input  wire logic [15:0] rdata,
    output bus_req_s         req,
    output logic             freeze
);
    initial
    begin
        req    = '0;
        freeze = 1'b0;
    end

    // Strobe lasts one cycle; lanes held until the answer, then scrambled
    task automatic access(input logic w, input logic [7:0] a, input logic [15:0] v,
                          output logic [15:0] data);
        int n;
        n = 0;
        @(posedge clk);
        #1;
        req = '{wr: w, rd: ~w, be: 2'h3, addr: a, wdata: v};
        @(posedge clk);
        #1;
        req.wr = 1'b0;
        req.rd = 1'b0;
        while (ack !== 1'b1 && n < 8)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        data = (ack === 1'b1) ? rdata : 16'hXXXX;
        @(posedge clk);
        #1;
        req.addr  = ~req.addr;
        req.wdata = ~req.wdata;
    endtask

    task automatic set_freeze(input logic on);
        @(posedge clk);
        #1;
        freeze = on;
    endtask
endmodule
`default_nettype wire

// >>> tb/serial_module_global_control_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "serial_ctrl_regs.svh"
module serial_module_global_control_test;
    import serial_ctrl_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    bus_req_s    bus_req;
    logic [15:0] bus_rdata;
    logic        bus_ack;
    logic        freeze;
    logic        sync_req = 1'b0;
    logic        async_req = 1'b0;
    logic        iack = 1'b0;
    logic [7:0]  vector;
    logic        vec_valid;
    logic [7:1]  irq_n;
    logic        stopped;
    logic        queue_busy;
    logic        halt_ack;
    logic [3:0]  cs_n;
    logic        ram_rd;
    logic        ram_wr;
    logic [15:0] ram_rdata;
    logic [1:0]  ram_be;
    logic [6:0]  ram_addr;
    logic [15:0] ram_wdata;
    async_cfg_s  async_cfg;
    logic        rxd = 1'b1;
    int          n_errors = 0;
    int          checks = 0;
    int          cycles = 0;
    int          rd_pulses = 0;
    int          wr_pulses = 0;

    always #5 sys_clk = ~sys_clk;
    assign ram_rdata = (ram_rd === 1'b1) ? 16'hA5C3 : 16'h5A3C;

    host_model u_host (.clk(sys_clk), .ack(bus_ack), .rdata(bus_rdata), .req(bus_req),
                       .freeze(freeze));

    serial_module_ctrl u_dut (
        .SYS_CLK(sys_clk), .RST_N(rst_n), .BUS_REQ(bus_req), .BUS_RDATA(bus_rdata),
        .BUS_ACK(bus_ack), .FREEZE(freeze), .SYNC_REQ(sync_req), .ASYNC_REQ(async_req),
        .IACK(iack), .IACK_LEVEL(3'h5), .VECTOR(vector), .VEC_VALID(vec_valid),
        .IRQ_N(irq_n), .RXD(rxd), .BAUD_TICK(), .ASYNC_CFG(async_cfg), .STOPPED(stopped),
        .QUEUE_PTR(), .QUEUE_BUSY(queue_busy), .HALT_ACK(halt_ack), .CS_N(cs_n),
        .SHIFT_STEP(), .RAM_RD(ram_rd), .RAM_WR(ram_wr), .RAM_BE(ram_be),
        .RAM_ADDR(ram_addr), .RAM_WDATA(ram_wdata), .RAM_RDATA(ram_rdata));

    always @(posedge sys_clk)
    begin
        cycles++;
        rd_pulses += (ram_rd === 1'b1);
        wr_pulses += (ram_wr === 1'b1);
        if (cycles == 5000)
        begin
            n_errors++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        logic [15:0] unused;
        u_host.access(1'b1, a, v, unused);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] got;
        u_host.access(1'b0, a, 16'h0000, got);
        check(what, exp, got);
    endtask

    task automatic ack_chk(input logic [7:0] exp);
        @(posedge sys_clk);
        #1;
        iack = 1'b1;
        @(posedge sys_clk);
        #1;
        iack = 1'b0;
        check("vector valid", 16'h0001, {15'h0000, vec_valid});
        check("vector", {8'h00, exp}, {8'h00, vector});
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wait_halt();
        int n;
        for (n = 0; n < 100 && halt_ack !== 1'b1; n++)
            @(posedge sys_clk);
        #1;
        check("halt ack", 16'h0001, {15'h0000, halt_ack});
    endtask

    initial
    begin
        settle(4);
        rst_n = 1'b1;
        check("stopped", 16'h0001, {15'h0000, stopped});
        check("vector", 16'h000F, {8'h00, vector});
        check("irq lines", 16'h007F, {9'h000, irq_n});
        rd_chk("config", `OFS_CONFIG, 16'h8000);
        wr(`OFS_IRQ, 16'hED54);
        wr(`OFS_BAUD, 16'hE001);
        rd_chk("level in stop", `OFS_IRQ, 16'h0000);
        rd_chk("ram in stop", 8'h80, 16'h0000);
        wr(8'h82, 16'h1234);
        check("ram reads", 16'h0000, rd_pulses[15:0]);
        check("ram writes", 16'h0001, wr_pulses[15:0]);
        check("ram addr", 16'h0002, {9'h000, ram_addr});
        check("ram wdata", 16'h1234, ram_wdata);
        check("ram be", 16'h0003, {14'h0000, ram_be});
        $display("test stop done");
        wr(`OFS_CONFIG, 16'h2000);
        check("stopped", 16'h0000, {15'h0000, stopped});
        rd_chk("config", `OFS_CONFIG, 16'h2000);
        rd_chk("level vector", `OFS_IRQ, 16'h2D55);
        rd_chk("unmapped", 8'h0E, 16'h0000);
        rd_chk("test word", `OFS_TEST, 16'h0000);
        rd_chk("baud", `OFS_BAUD, 16'h0001);
        rd_chk("ram", 8'h80, 16'hA5C3);
        wr(`OFS_ASYNC, 16'hFFFF);
        check("async cfg", 16'h001F, {11'h000, async_cfg});
        settle(8);
        // Low for two clocks: exactly one sample at a tick every two clocks
        rxd = 1'b0;
        settle(2);
        rxd = 1'b1;
        settle(12);
        rd_chk("noise", `OFS_STATUS, 16'h0100);
        wr(`OFS_STATUS, 16'h0100);
        rd_chk("noise cleared", `OFS_STATUS, 16'h0000);
        $display("test registers done");
        sync_req = 1'b1;
        async_req = 1'b1;
        settle(2);
        check("irq lines", 16'h006F, {9'h000, irq_n});
        ack_chk(8'h55);
        sync_req = 1'b0;
        settle(2);
        ack_chk(8'h54);
        async_req = 1'b0;
        wr(`OFS_IRQ, 16'h3854);
        sync_req = 1'b1;
        settle(2);
        check("irq lines", 16'h003F, {9'h000, irq_n});
        sync_req = 1'b0;
        $display("test interrupts done");
        u_host.set_freeze(1'b1);
        wr(`OFS_QUEUE, 16'hC508);
        settle(12);
        check("chip selects", 16'h000A, {12'h000, cs_n});
        check("halt ack", 16'h0000, {15'h0000, halt_ack});
        wr(`OFS_CONFIG, 16'h4000);
        wait_halt();
        settle(40);
        check("busy", 16'h0001, {15'h0000, queue_busy});
        rd_chk("status", `OFS_STATUS, 16'hC000);
        check("chip selects", 16'h000F, {12'h000, cs_n});
        wr(`OFS_QUEUE, 16'hE508);
        u_host.set_freeze(1'b0);
        wr(`OFS_CONFIG, 16'h0000);
        settle(40);
        check("halt ack", 16'h0001, {15'h0000, halt_ack});
        check("chip selects", 16'h000F, {12'h000, cs_n});
        wr(`OFS_IRQ, 16'h0054);
        wr(`OFS_ASYNC, 16'h0000);
        wr(`OFS_CONFIG, 16'h8000);
        settle(2);
        check("stopped", 16'h0001, {15'h0000, stopped});
        rd_chk("config", `OFS_CONFIG, 16'h8000);
        $display("test queue halt done");
        summarize();
    end
endmodule
`default_nettype wire
